/* File: verilog/asc_consts.vh */
// Purpose: shared constants of the amplifier setup command decoder
// Assumes: byte-wide command stream, Avalon-MM register slave, byte addresses
// Notes: offsets, field positions, reset values and command codes
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

`define ASC_SYNC_HI 8'hAA
`define ASC_SYNC_LO 8'h55
`define ASC_PKT_LEN 8'h07

`define ASC_CMD_MODE 8'h21
`define ASC_CMD_ATTEN 8'h23
`define ASC_CMD_TEMP_THR 8'h24
`define ASC_CMD_TEMP_EN 8'h25
`define ASC_CMD_LOW_THR 8'h26
`define ASC_CMD_LOW_EN 8'h27
`define ASC_CMD_HIGH_THR 8'h28
`define ASC_CMD_HIGH_EN 8'h29
`define ASC_CMD_REFL_THR 8'h2A

`define ASC_UNIT_MIN 8'h01
`define ASC_UNIT_MAX 8'h03
`define ASC_ATTEN_MIN 8'h00
`define ASC_ATTEN_MAX 8'h14
`define ASC_TEMP_MIN 8'h28
`define ASC_TEMP_MAX 8'h50
`define ASC_PWR_MIN 8'h10
`define ASC_PWR_MAX 8'h38
`define ASC_FLAG_MAX 8'h01

`define ASC_OFS_STATUS 5'h00
`define ASC_OFS_CLEAR 5'h04
`define ASC_OFS_ENABLE 5'h08
`define ASC_OFS_SYSADDR 5'h0C
`define ASC_OFS_THRESH 5'h10
`define ASC_OFS_STATE 5'h14

`define ASC_EV_ACK 0
`define ASC_EV_NAK 1
`define ASC_EV_FRAME_ERR 2
`define ASC_EV_MODE_CHG 3
`define ASC_EV_W 4

`define ASC_RST_SYSADDR 5'h01
`define ASC_RST_TEMP_THR 8'h46
`define ASC_RST_LOW_THR 8'h10
`define ASC_RST_HIGH_THR 8'h38
`define ASC_RST_REFL_THR 8'h38
`define ASC_RST_ATTEN 8'h00

`endif

/* File: verilog/asc_frame_rx.v */
// Purpose: finds command frames in the byte stream and checks them
// Assumes: one byte per cycle at most, flagged by byte_valid_in
// Notes: fields hold until the next frame body of the right length, checksum good or not
`timescale 1ns/1ps
`default_nettype none
`include "asc_consts.vh"
module asc_frame_rx (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire [7:0] byte_in,
    input wire byte_valid_in,
    output reg frame_ok_out,
    output reg frame_err_out,
    output reg [7:0] dest_out,
    output reg [7:0] src_out,
    output reg [7:0] cmd_out,
    output reg [7:0] unit_out,
    output reg [7:0] data_out
);
    localparam [1:0] ST_HUNT0 = 2'b00;
    localparam [1:0] ST_HUNT1 = 2'b01;
    localparam [1:0] ST_LEN = 2'b10;
    localparam [1:0] ST_BODY = 2'b11;

    reg [1:0] state;
    reg [2:0] count;
    reg [7:0] sum;

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_HUNT0;
            count <= 3'h0;
            sum <= 8'h00;
            frame_ok_out <= 1'b0;
            frame_err_out <= 1'b0;
            dest_out <= 8'h00;
            src_out <= 8'h00;
            cmd_out <= 8'h00;
            unit_out <= 8'h00;
            data_out <= 8'h00;
        end else begin
            frame_ok_out <= 1'b0;
            frame_err_out <= 1'b0;
            if (byte_valid_in) begin
                case (state)
                    ST_HUNT0: begin
                        if (byte_in == `ASC_SYNC_HI) state <= ST_HUNT1;
                    end
                    ST_HUNT1: begin
                        if (byte_in == `ASC_SYNC_LO) state <= ST_LEN;
                        else if (byte_in != `ASC_SYNC_HI) state <= ST_HUNT0;
                    end
                    ST_LEN: begin
                        count <= 3'h0;
                        sum <= byte_in;
                        if (byte_in == `ASC_PKT_LEN) begin
                            state <= ST_BODY;
                        end else begin
                            state <= ST_HUNT0;
                            frame_err_out <= 1'b1;
                        end
                    end
                    default: begin
                        count <= count + 3'h1;
                        sum <= sum + byte_in;
                        case (count)
                            3'h0: dest_out <= byte_in;
                            3'h1: src_out <= byte_in;
                            3'h2: cmd_out <= byte_in;
                            3'h3: unit_out <= byte_in;
                            3'h4: data_out <= byte_in;
                            default: begin
                                state <= ST_HUNT0;
                                frame_ok_out <= (byte_in == sum);
                                frame_err_out <= (byte_in != sum);
                            end
                        endcase
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/asc_top.v */
// Purpose: decodes and applies setup commands, monitors power and temperature
// Assumes: inputs synchronous to ref_clk_in; measurements are unsigned bytes
// Notes: responses are one-cycle pulses; registers on Avalon-MM
`timescale 1ns/1ps
`default_nettype none
`include "asc_consts.vh"
module asc_top #(
    parameter [7:0] UNIT_ID = 8'h01,
    parameter REFL_OPTION = 1
) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire [7:0] rx_byte_in,
    input wire rx_valid_in,
    input wire parallel_port_enable_switch_in,
    input wire [7:0] temp_meas_in,
    input wire [7:0] fwd_power_in,
    input wire [7:0] refl_power_in,
    input wire overtemp_trip_in,
    input wire [4:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    output reg irq_out,
    output reg resp_ack_out,
    output reg resp_nak_out,
    output reg [7:0] resp_cmd_out,
    output reg [7:0] resp_dest_out,
    output reg [7:0] resp_unit_out,
    output reg [7:0] atten_level_out,
    output reg operations_mode_sel_out,
    output reg high_temp_out,
    output reg low_power_out,
    output reg high_power_out,
    output reg refl_high_out,
    output reg overtemp_shutdown_out,
    output reg rf_out_led_out,
    output reg summary_fault_out
);
    wire frm_ok;
    wire frm_err;
    wire [7:0] frm_dest;
    wire [7:0] frm_src;
    wire [7:0] frm_cmd;
    wire [7:0] frm_unit;
    wire [7:0] frm_data;

    reg [4:0] sys_addr;
    reg setup_mode;
    reg [7:0] temp_thr;
    reg [7:0] low_thr;
    reg [7:0] high_thr;
    reg [7:0] refl_thr;
    reg temp_fault_en;
    reg low_fault_en;
    reg high_fault_en;
    reg [`ASC_EV_W-1:0] status;
    reg [`ASC_EV_W-1:0] irq_en;

    reg next_setup_mode;
    reg [7:0] next_atten;
    reg [7:0] next_temp_thr;
    reg [7:0] next_low_thr;
    reg [7:0] next_high_thr;
    reg [7:0] next_refl_thr;
    reg next_temp_fault_en;
    reg next_low_fault_en;
    reg next_high_fault_en;
    reg next_ack;
    reg next_nak;
    reg next_mode_chg;
    reg [`ASC_EV_W-1:0] events;
    reg [`ASC_EV_W-1:0] clr_mask;
    reg [`ASC_EV_W-1:0] next_status;
    reg [31:0] rd_word;

    wire for_us;
    wire unit_ok;
    wire hi_temp;
    wire lo_pwr;
    wire hi_pwr;
    wire hi_refl;
    wire wr_go;

    function in_range;
        input [7:0] value;
        input [7:0] lo;
        input [7:0] hi;
        begin
            in_range = (value >= lo) && (value <= hi);
        end
    endfunction

    asc_frame_rx u_frame_rx (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .byte_in(rx_byte_in),
        .byte_valid_in(rx_valid_in),
        .frame_ok_out(frm_ok),
        .frame_err_out(frm_err),
        .dest_out(frm_dest),
        .src_out(frm_src),
        .cmd_out(frm_cmd),
        .unit_out(frm_unit),
        .data_out(frm_data)
    );

    // frames for another system address or another unit in range 1 to 3 are dropped silently
    assign for_us = frm_ok && (frm_dest == {3'b000, sys_addr});
    assign unit_ok = in_range(frm_unit, `ASC_UNIT_MIN, `ASC_UNIT_MAX);

    always @* begin
        next_setup_mode = setup_mode;
        next_atten = atten_level_out;
        next_temp_thr = temp_thr;
        next_low_thr = low_thr;
        next_high_thr = high_thr;
        next_refl_thr = refl_thr;
        next_temp_fault_en = temp_fault_en;
        next_low_fault_en = low_fault_en;
        next_high_fault_en = high_fault_en;
        next_ack = 1'b0;
        next_nak = 1'b0;
        next_mode_chg = 1'b0;
        if (for_us && !unit_ok) begin
            next_nak = 1'b1;
        end else if (for_us && (frm_unit == UNIT_ID)) begin
            next_nak = 1'b1;
            if (frm_cmd == `ASC_CMD_MODE) begin
                if (in_range(frm_data, 8'h00, `ASC_FLAG_MAX)) begin
                    next_setup_mode = frm_data[0];
                    next_mode_chg = (frm_data[0] != setup_mode);
                    next_ack = 1'b1;
                end
            end else if (frm_cmd == `ASC_CMD_ATTEN) begin
                if (!parallel_port_enable_switch_in &&
                    in_range(frm_data, `ASC_ATTEN_MIN, `ASC_ATTEN_MAX)) begin
                    next_atten = frm_data;
                    next_ack = 1'b1;
                end
            end else if (setup_mode) begin
                if (frm_cmd == `ASC_CMD_TEMP_THR) begin
                    if (in_range(frm_data, `ASC_TEMP_MIN, `ASC_TEMP_MAX)) begin
                        next_temp_thr = frm_data;
                        next_ack = 1'b1;
                    end
                end else if (frm_cmd == `ASC_CMD_TEMP_EN) begin
                    if (in_range(frm_data, 8'h00, `ASC_FLAG_MAX)) begin
                        next_temp_fault_en = frm_data[0];
                        next_ack = 1'b1;
                    end
                end else if (frm_cmd == `ASC_CMD_LOW_THR) begin
                    if (in_range(frm_data, `ASC_PWR_MIN, `ASC_PWR_MAX)) begin
                        next_low_thr = frm_data;
                        next_ack = 1'b1;
                    end
                end else if (frm_cmd == `ASC_CMD_LOW_EN) begin
                    if (in_range(frm_data, 8'h00, `ASC_FLAG_MAX)) begin
                        next_low_fault_en = frm_data[0];
                        next_ack = 1'b1;
                    end
                end else if (frm_cmd == `ASC_CMD_HIGH_THR) begin
                    if (in_range(frm_data, `ASC_PWR_MIN, `ASC_PWR_MAX)) begin
                        next_high_thr = frm_data;
                        next_ack = 1'b1;
                    end
                end else if (frm_cmd == `ASC_CMD_HIGH_EN) begin
                    if (in_range(frm_data, 8'h00, `ASC_FLAG_MAX)) begin
                        next_high_fault_en = frm_data[0];
                        next_ack = 1'b1;
                    end
                end else if (frm_cmd == `ASC_CMD_REFL_THR) begin
                    if ((REFL_OPTION != 0) &&
                        in_range(frm_data, `ASC_PWR_MIN, `ASC_PWR_MAX)) begin
                        next_refl_thr = frm_data;
                        next_ack = 1'b1;
                    end
                end
            end
            if (next_ack) next_nak = 1'b0;
        end
    end

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            setup_mode <= 1'b0;
            atten_level_out <= `ASC_RST_ATTEN;
            temp_thr <= `ASC_RST_TEMP_THR;
            low_thr <= `ASC_RST_LOW_THR;
            high_thr <= `ASC_RST_HIGH_THR;
            refl_thr <= `ASC_RST_REFL_THR;
            temp_fault_en <= 1'b0;
            low_fault_en <= 1'b0;
            high_fault_en <= 1'b0;
            resp_ack_out <= 1'b0;
            resp_nak_out <= 1'b0;
            resp_cmd_out <= 8'h00;
            resp_dest_out <= 8'h00;
            resp_unit_out <= 8'h00;
            operations_mode_sel_out <= 1'b1;
        end else begin
            setup_mode <= next_setup_mode;
            operations_mode_sel_out <= !next_setup_mode;
            atten_level_out <= next_atten;
            temp_thr <= next_temp_thr;
            low_thr <= next_low_thr;
            high_thr <= next_high_thr;
            refl_thr <= next_refl_thr;
            temp_fault_en <= next_temp_fault_en;
            low_fault_en <= next_low_fault_en;
            high_fault_en <= next_high_fault_en;
            resp_ack_out <= next_ack;
            resp_nak_out <= next_nak;
            if (next_ack || next_nak) begin
                resp_cmd_out <= frm_cmd;
                resp_dest_out <= frm_src;
                resp_unit_out <= frm_unit;
            end
        end
    end

    // monitoring against the stored thresholds
    assign hi_temp = temp_meas_in > temp_thr;
    assign lo_pwr = fwd_power_in < low_thr;
    assign hi_pwr = fwd_power_in > high_thr;
    assign hi_refl = (REFL_OPTION != 0) && (refl_power_in > refl_thr);

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            high_temp_out <= 1'b0;
            low_power_out <= 1'b0;
            high_power_out <= 1'b0;
            refl_high_out <= 1'b0;
            rf_out_led_out <= 1'b0;
            summary_fault_out <= 1'b0;
            overtemp_shutdown_out <= 1'b0;
        end else begin
            high_temp_out <= hi_temp;
            low_power_out <= lo_pwr;
            high_power_out <= hi_pwr;
            refl_high_out <= hi_refl;
            rf_out_led_out <= !lo_pwr;
            summary_fault_out <= (hi_temp && temp_fault_en) ||
                                 (lo_pwr && low_fault_en) ||
                                 (hi_pwr && high_fault_en);
            // trip latches; recovery once back at or below threshold
            if (overtemp_trip_in) overtemp_shutdown_out <= 1'b1;
            else if (!hi_temp) overtemp_shutdown_out <= 1'b0;
        end
    end

    // register slave: one wait cycle, then a one-cycle answer
    assign wr_go = avs_write_in && !avs_waitrequest_out;

    always @* begin
        events = {`ASC_EV_W{1'b0}};
        events[`ASC_EV_ACK] = next_ack;
        events[`ASC_EV_NAK] = next_nak;
        events[`ASC_EV_FRAME_ERR] = frm_err;
        events[`ASC_EV_MODE_CHG] = next_mode_chg;
        clr_mask = {`ASC_EV_W{1'b0}};
        if (wr_go && (avs_address_in == `ASC_OFS_CLEAR) && avs_byteenable_in[0])
            clr_mask = avs_writedata_in[`ASC_EV_W-1:0];
        // a new event wins over a clear in the same cycle
        next_status = (status & ~clr_mask) | events;
    end

    always @* begin
        rd_word = 32'h0000_0000;
        if (avs_address_in == `ASC_OFS_STATUS) begin
            rd_word[`ASC_EV_W-1:0] = status;
        end else if (avs_address_in == `ASC_OFS_ENABLE) begin
            rd_word[`ASC_EV_W-1:0] = irq_en;
        end else if (avs_address_in == `ASC_OFS_SYSADDR) begin
            rd_word[4:0] = sys_addr;
        end else if (avs_address_in == `ASC_OFS_THRESH) begin
            rd_word = {refl_thr, high_thr, low_thr, temp_thr};
        end else if (avs_address_in == `ASC_OFS_STATE) begin
            rd_word[7:0] = atten_level_out;
            rd_word[8] = setup_mode;
            rd_word[9] = temp_fault_en;
            rd_word[10] = low_fault_en;
            rd_word[11] = high_fault_en;
            rd_word[12] = overtemp_shutdown_out;
            rd_word[13] = summary_fault_out;
            rd_word[14] = parallel_port_enable_switch_in;
        end
    end

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
            status <= {`ASC_EV_W{1'b0}};
            irq_en <= {`ASC_EV_W{1'b0}};
            sys_addr <= `ASC_RST_SYSADDR;
            irq_out <= 1'b0;
        end else begin
            if ((avs_read_in || avs_write_in) && avs_waitrequest_out)
                avs_waitrequest_out <= 1'b0;
            else
                avs_waitrequest_out <= 1'b1;
            if (avs_read_in && avs_waitrequest_out)
                avs_readdata_out <= rd_word;
            status <= next_status;
            if (wr_go && avs_byteenable_in[0]) begin
                if (avs_address_in == `ASC_OFS_ENABLE)
                    irq_en <= avs_writedata_in[`ASC_EV_W-1:0];
                else if (avs_address_in == `ASC_OFS_SYSADDR)
                    sys_addr <= avs_writedata_in[4:0];
            end
            irq_out <= |(next_status & irq_en);
        end
    end
endmodule
`default_nettype wire

/* File: test/asc_top_monitor.sv */
// Purpose: port-level checks of the setup command decoder
// Assumes: single clock domain, async active-low reset
// Notes: bound into asc_top below
`timescale 1ns/1ps
`default_nettype none
module asc_top_monitor (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic parallel_port_enable_switch_in,
    input wire logic overtemp_trip_in,
    input wire logic resp_ack_out,
    input wire logic resp_nak_out,
    input wire logic [7:0] resp_cmd_out,
    input wire logic [7:0] atten_level_out,
    input wire logic operations_mode_sel_out,
    input wire logic low_power_out,
    input wire logic rf_out_led_out,
    input wire logic overtemp_shutdown_out,
    input wire logic irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    a_resp_excl: assert property (!(resp_ack_out && resp_nak_out))
        else $error("ack and nak together");
    a_ack_pulse: assert property (resp_ack_out |=> !resp_ack_out)
        else $error("ack longer than one cycle");
    a_nak_pulse: assert property (resp_nak_out |=> !resp_nak_out)
        else $error("nak longer than one cycle");
    a_led_vs_low: assert property ($past(reset_n_in) |-> rf_out_led_out != low_power_out)
        else $error("lamp and low power flag disagree");
    a_atten_switch: assert property ($changed(atten_level_out) |->
        !$past(parallel_port_enable_switch_in) && atten_level_out <= 8'h14)
        else $error("attenuation changed illegally");
    a_nak_keeps: assert property (resp_nak_out |-> $stable(atten_level_out))
        else $error("attenuation changed on nak");
    a_ops_refuse: assert property (operations_mode_sel_out && resp_ack_out |->
        !(resp_cmd_out inside {[8'h24:8'h2A]}))
        else $error("setup command acked in operations mode");
    a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |-> ##[1:2] !avs_waitrequest_out)
        else $error("bus request not answered");
    a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    a_trip_latch: assert property (overtemp_trip_in |-> ##[1:2] overtemp_shutdown_out)
        else $error("trip did not set shutdown");
    c_atten_ack: cover property (resp_ack_out && resp_cmd_out == 8'h23);
    c_nak: cover property (resp_nak_out);
    c_irq: cover property (irq_out);
    c_recover: cover property ($fell(overtemp_shutdown_out));
endmodule
bind asc_top asc_top_monitor u_mon (.ref_clk_in, .reset_n_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .parallel_port_enable_switch_in, .overtemp_trip_in, .resp_ack_out,
    .resp_nak_out, .resp_cmd_out, .atten_level_out, .operations_mode_sel_out, .low_power_out,
    .rf_out_led_out, .overtemp_shutdown_out, .irq_out);
`default_nettype wire

/* File: test/asc_host_model.sv */
// Purpose: monitor-and-control host sending command frames
// Assumes: caller enters send just after a rising edge
// Notes: idle byte line shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
    input wire logic ref_clk_in,
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out
);
    initial begin
        rx_byte_out = 8'h00;
        rx_valid_out = 1'b0;
    end
    task automatic send(input logic [7:0] dest, len, cmd, unit, val, flip);
        logic [7:0] f [9];
        logic [7:0] sum;
        int i;
        sum = len + dest + 8'h10 + cmd + unit + val;
        f = '{8'hAA, 8'h55, len, dest, 8'h10, cmd, unit, val, sum ^ flip};
        for (i = 0; i < 9; i++) begin
            rx_byte_out <= f[i];
            rx_valid_out <= 1'b1;
            @(posedge ref_clk_in);
        end
        rx_valid_out <= 1'b0;
        rx_byte_out <= ~f[8];
    endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: self-checking bench of the setup command decoder
// Assumes: unit id 1, reflected option fitted, system address 1
// Notes: frame task waits for each answer before the next frame
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [1:0] NONE = 2'b00;
    localparam logic [1:0] ACK = 2'b01;
    localparam logic [1:0] NAK = 2'b10;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] rx_byte, rcmd, rdest, runit, atten;
    logic [7:0] temp = 8'h19, fwd = 8'h24, refl = 8'h20;
    logic rx_valid, sw = 1'b0, trip = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0, dout, rdata;
    logic wreq, irq, ack, nak, operations_mode_sel, ht, lp, hp, rh, sd, led, sf;
    int n_errors = 0;
    int cmp_count = 0;
    initial forever #4 ref_clk_in = ~ref_clk_in;
    asc_host_model host (.ref_clk_in(ref_clk_in), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid));
    asc_top dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .rx_byte_in(rx_byte),
        .rx_valid_in(rx_valid), .parallel_port_enable_switch_in(sw), .temp_meas_in(temp),
        .fwd_power_in(fwd), .refl_power_in(refl), .overtemp_trip_in(trip),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(dout), .avs_waitrequest_out(wreq),
        .irq_out(irq), .resp_ack_out(ack), .resp_nak_out(nak), .resp_cmd_out(rcmd),
        .resp_dest_out(rdest), .resp_unit_out(runit), .atten_level_out(atten),
        .operations_mode_sel_out(operations_mode_sel), .high_temp_out(ht), .low_power_out(lp),
        .high_power_out(hp), .refl_high_out(rh), .overtemp_shutdown_out(sd),
        .rf_out_led_out(led), .summary_fault_out(sf));
    task results;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task settle;
        repeat (3) @(posedge ref_clk_in);
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk_in);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk_in);
            if (wreq === 1'b0) break;
        end
        rdata = dout;
        wr <= 1'b0;
        rd <= 1'b0;
        if (i == 20) begin
            n_errors++;
            results();
        end
    endtask
    task rdchk(input string n, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rdata);
    endtask
    task frame(input logic [7:0] d, l, c, u, v, x, input logic [1:0] e);
        int i;
        logic [1:0] seen;
        @(posedge ref_clk_in);
        host.send(d, l, c, u, v, x);
        seen = NONE;
        for (i = 0; i < 8 && seen === NONE; i++) begin
            @(posedge ref_clk_in);
            seen = {nak, ack};
        end
        chk("response", e, seen);
        if (e == ACK)
            chk("resp cmd", c, rcmd);
        if (e != NONE) begin
            chk("resp dest", 8'h10, rdest);
            chk("resp unit", u, runit);
        end
        if (e != NONE && seen === NONE)
            results();
        settle;
    endtask
    task cmd(input logic [7:0] c, v, input logic [1:0] e);
        frame(8'h01, 8'h07, c, 8'h01, v, 8'h00, e);
    endtask
    task t_reset;
        chk("ops mode", 1, operations_mode_sel);
        chk("atten", 0, atten);
        rdchk("thresh", 5'h10, 32'h38381046);
        bus(1'b1, 5'h10, 32'hFFFFFFFF);
        rdchk("thresh ro", 5'h10, 32'h38381046);
        rdchk("state", 5'h14, 32'h0);
        rdchk("unmapped", 5'h18, 32'h0);
        rdchk("sysaddr", 5'h0C, 32'h1);
    endtask
    task t_mode;
        cmd(8'h24, 8'h3C, NAK);
        cmd(8'h21, 8'h01, ACK);
        chk("ops mode", 0, operations_mode_sel);
        cmd(8'h21, 8'h02, NAK);
        chk("ops mode", 0, operations_mode_sel);
    endtask
    task t_atten;
        cmd(8'h23, 8'h14, ACK);
        chk("atten", 8'h14, atten);
        cmd(8'h23, 8'h15, NAK);
        chk("atten", 8'h14, atten);
        sw <= 1'b1;
        cmd(8'h23, 8'h05, NAK);
        rdchk("state", 5'h14, 32'h4114);
        sw <= 1'b0;
        cmd(8'h23, 8'h00, ACK);
        chk("atten", 8'h00, atten);
    endtask
    task t_setup;
        logic [7:0] good [7] = '{8'h28, 8'h01, 8'h20, 8'h01, 8'h30, 8'h01, 8'h30};
        logic [15:0] bad [6] = '{16'h2427, 16'h2451, 16'h260F, 16'h2639, 16'h2A39, 16'h2502};
        int i;
        for (i = 0; i < 7; i++)
            cmd(8'(8'h24 + i), good[i], ACK);
        for (i = 0; i < 6; i++)
            cmd(bad[i][15:8], bad[i][7:0], NAK);
        rdchk("thresh", 5'h10, 32'h30302028);
        rdchk("state", 5'h14, 32'h0F00);
        cmd(8'h29, 8'h00, ACK);
        rdchk("state", 5'h14, 32'h0700);
        cmd(8'h29, 8'h01, ACK);
    endtask
    task t_monitor;
        fwd <= 8'h20;
        settle;
        chk("lamp", 1, led);
        chk("low power", 0, lp);
        fwd <= 8'h1F;
        settle;
        chk("lamp", 0, led);
        chk("summary", 1, sf);
        fwd <= 8'h31;
        settle;
        chk("high power", 1, hp);
        chk("summary", 1, sf);
        fwd <= 8'h30;
        refl <= 8'h31;
        settle;
        chk("summary", 0, sf);
        chk("refl high", 1, rh);
        refl <= 8'h20;
        temp <= 8'h29;
        settle;
        chk("high temp", 1, ht);
        chk("summary", 1, sf);
        trip <= 1'b1;
        @(posedge ref_clk_in);
        trip <= 1'b0;
        settle;
        chk("shutdown", 1, sd);
        temp <= 8'h28;
        settle;
        chk("shutdown", 0, sd);
        chk("high temp", 0, ht);
        fwd <= 8'h24;
    endtask
    task t_irq;
        rdchk("status", 5'h00, 32'hB);
        bus(1'b1, 5'h08, 32'h2);
        settle;
        chk("irq", 1, irq);
        bus(1'b1, 5'h04, 32'hF);
        settle;
        chk("irq", 0, irq);
        cmd(8'h21, 8'h07, NAK);
        chk("irq", 1, irq);
        rdchk("status", 5'h00, 32'h2);
        bus(1'b1, 5'h08, 32'h0);
        settle;
        chk("irq", 0, irq);
        bus(1'b1, 5'h04, 32'hF);
    endtask
    task t_errs;
        frame(8'h01, 8'h07, 8'h21, 8'h01, 8'h01, 8'h01, NONE);
        rdchk("status", 5'h00, 32'h4);
        frame(8'h01, 8'h08, 8'h21, 8'h01, 8'h01, 8'h00, NONE);
        frame(8'h02, 8'h07, 8'h21, 8'h01, 8'h00, 8'h00, NONE);
        frame(8'h01, 8'h07, 8'h21, 8'h04, 8'h00, 8'h00, NAK);
        frame(8'h01, 8'h07, 8'h21, 8'h02, 8'h00, 8'h00, NONE);
        chk("ops mode", 0, operations_mode_sel);
        cmd(8'h21, 8'h00, ACK);
        chk("ops mode", 1, operations_mode_sel);
        cmd(8'h26, 8'h30, NAK);
        rdchk("thresh", 5'h10, 32'h30302028);
        bus(1'b1, 5'h0C, 32'h2);
        rdchk("sysaddr", 5'h0C, 32'h2);
        frame(8'h01, 8'h07, 8'h23, 8'h01, 8'h05, 8'h00, NONE);
        frame(8'h02, 8'h07, 8'h23, 8'h01, 8'h05, 8'h00, ACK);
        chk("atten", 8'h05, atten);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        t_reset;
        t_mode;
        t_atten;
        t_setup;
        t_monitor;
        t_irq;
        t_errs;
        results();
    end
endmodule
`default_nettype wire
